// file: rtl/bus_target_error_log_pkg.sv
`default_nettype none
package bus_target_error_log_pkg;

  // register map
  localparam logic [3:0] LOG1_ADDR = 4'h0; // error log register, byte address
  localparam logic [3:0] VIOL_ADDR = 4'h4; // violation counter, read only

  // field positions in the log register
  localparam int MULTI_BIT = 31;
  localparam int CODE_LSB = 24;
  localparam int REQ_ID_LSB = 8;
  localparam int REGION_LSB = 4;
  localparam int CMD_LSB = 0;

  // error type codes
  localparam logic [3:0] CODE_NONE = 4'h0;
  localparam logic [3:0] CODE_PERM_VIOL = 4'h3;

  // requester source selections
  localparam logic [3:0] SRC_CPU = 4'h0;
  localparam logic [3:0] SRC_DMA_RD = 4'h1;
  localparam logic [3:0] SRC_DMA_WR = 4'h2;
  localparam logic [3:0] SRC_USB = 4'h3;
  localparam logic [3:0] SRC_NET_RD = 4'h4;
  localparam logic [3:0] SRC_NET_WR = 4'h5;
  localparam logic [3:0] SRC_CAN1 = 4'h6;
  localparam logic [3:0] SRC_CAN2 = 4'h7;
  localparam logic [3:0] SRC_SFLASH = 4'h8;
  localparam logic [3:0] SRC_FLASH = 4'h9;
  localparam logic [3:0] SRC_CRYPTO = 4'ha;

  // requester identity codes
  localparam logic [7:0] ID_RESERVED = 8'h00;
  localparam logic [7:0] ID_CPU_LO = 8'h01;
  localparam logic [7:0] ID_CPU_HI = 8'h02;
  localparam logic [7:0] ID_DMA_RD_LO = 8'h03;
  localparam logic [7:0] ID_DMA_RD_HI = 8'h04;
  localparam logic [7:0] ID_DMA_WR_LO = 8'h05;
  localparam logic [7:0] ID_DMA_WR_HI = 8'h06;
  localparam logic [7:0] ID_USB = 8'h07;
  localparam logic [7:0] ID_NET_RD = 8'h08;
  localparam logic [7:0] ID_NET_WR = 8'h09;
  localparam logic [7:0] ID_CAN1 = 8'h0a;
  localparam logic [7:0] ID_CAN2 = 8'h0b;
  localparam logic [7:0] ID_SFLASH = 8'h0c;
  localparam logic [7:0] ID_FLASH = 8'h0d;
  localparam logic [7:0] ID_CRYPTO = 8'h0e;

  // reset values
  localparam logic [31:0] LOG1_RESET = 32'h0000_0000;
  localparam logic [15:0] VIOL_RESET = 16'h0000;

endpackage
`default_nettype wire

// file: rtl/requester_id_map.sv
`timescale 1ns/1ps
`default_nettype none
module requester_id_map
  import bus_target_error_log_pkg::*;
(
  input wire logic [3:0] i_src, // requester source selection
  input wire logic i_cpu_pri, // processor_priority_select
  input wire logic i_dma_pri, // dma_priority_select
  output logic [7:0] o_id // requester_identity code
);

  // map source and priority selects onto identity code
  always_comb begin
    case (i_src)
      SRC_CPU: o_id = i_cpu_pri ? ID_CPU_HI : ID_CPU_LO; // [RULE4]
      SRC_DMA_RD: o_id = i_dma_pri ? ID_DMA_RD_HI : ID_DMA_RD_LO; // [RULE5]
      SRC_DMA_WR: o_id = i_dma_pri ? ID_DMA_WR_HI : ID_DMA_WR_LO; // [RULE5]
      SRC_USB: o_id = ID_USB; // [RULE6]
      SRC_NET_RD: o_id = ID_NET_RD; // [RULE6]
      SRC_NET_WR: o_id = ID_NET_WR; // [RULE6]
      SRC_CAN1: o_id = ID_CAN1; // [RULE6]
      SRC_CAN2: o_id = ID_CAN2; // [RULE6]
      SRC_SFLASH: o_id = ID_SFLASH; // [RULE6]
      SRC_FLASH: o_id = ID_FLASH; // [RULE6]
      SRC_CRYPTO: o_id = ID_CRYPTO; // [RULE6]
      default: o_id = ID_RESERVED;
    endcase
  end

endmodule // requester_id_map
`default_nettype wire

// file: rtl/bus_target_error_log.sv
// Behaviour
// [RULE1] error code: 0011 violation, 0000 none
// [RULE2] writing one to code clears it
// [RULE3] multi flag bit 31, write-one clear
// [RULE4] processor identity follows processor priority select
// [RULE5] dma identity by direction and priority
// [RULE6] fixed identity codes for other initiators
// [RULE7] first violation captures; later only sets multi
`timescale 1ns/1ps
`default_nettype none
module bus_target_error_log
  import bus_target_error_log_pkg::*;
(
  input wire logic i_sys_clk, // system bus clock
  input wire logic i_srst, // synchronous reset, active high
  input wire logic [3:0] i_avs_address, // byte address
  input wire logic i_avs_read, // read request
  input wire logic i_avs_write, // write request
  input wire logic [31:0] i_avs_writedata, // write data
  input wire logic [3:0] i_avs_byteenable, // byte lanes
  output logic [31:0] o_avs_readdata, // read data
  output logic o_avs_waitrequest, // stall
  input wire logic i_viol_valid, // one-cycle violation pulse
  input wire logic [3:0] i_viol_src, // offending requester source
  input wire logic [3:0] i_viol_region, // offending region
  input wire logic [2:0] i_viol_cmd, // offending command
  input wire logic i_cpu_pri, // processor_priority_select
  input wire logic i_dma_pri, // dma_priority_select
  output logic o_error_logged, // code field non-zero
  output logic o_multi // multiple violation flag
);

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [3:0] code;
  logic multi;
  logic [7:0] req_id;
  logic [3:0] region;
  logic [2:0] cmd;
  logic [15:0] viol_count;
  logic ack;
  logic [31:0] rdata;

  ////////////////////////////////////////////////////////////////////////
  // decode
  wire [7:0] id_now;
  wire sel_log = (i_avs_address == LOG1_ADDR);
  wire sel_viol = (i_avs_address == VIOL_ADDR);
  wire wr_take = i_avs_write && ack;
  wire clr_code = wr_take && sel_log && i_avs_byteenable[3] && (i_avs_writedata[27:24] != 4'h0);
  wire clr_multi = wr_take && sel_log && i_avs_byteenable[3] && i_avs_writedata[MULTI_BIT];
  wire first_viol = i_viol_valid && (code == CODE_NONE);
  wire again_viol = i_viol_valid && (code != CODE_NONE);
  wire [31:0] log_word = {multi, 3'h0, code, 8'h00, req_id, region, 1'b0, cmd};

  requester_id_map u_id_map (
    .i_src(i_viol_src),
    .i_cpu_pri(i_cpu_pri),
    .i_dma_pri(i_dma_pri),
    .o_id(id_now)
  );

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (sel_log) begin
      rdata = log_word;
    end else if (sel_viol) begin
      rdata = {16'h0000, viol_count};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, answered on the second edge
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      ack <= 1'b0;
    end else begin
      ack <= (i_avs_read || i_avs_write) && !ack;
    end
  end

  // read data register, loaded in the wait cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && !ack) begin
      o_avs_readdata <= rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // error code: a first violation wins over a same-cycle clear
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      code <= LOG1_RESET[27:24];
    end else if (first_viol) begin
      code <= CODE_PERM_VIOL; // [RULE1] [RULE7]
    end else if (clr_code) begin
      code <= CODE_NONE; // [RULE2]
    end
  end

  // multiple violation flag, set wins over clear
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      multi <= LOG1_RESET[MULTI_BIT];
    end else if (again_viol) begin
      multi <= 1'b1; // [RULE3] [RULE7]
    end else if (clr_multi) begin
      multi <= 1'b0; // [RULE3]
    end
  end

  // capture details only on the first violation
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      req_id <= LOG1_RESET[15:8];
      region <= LOG1_RESET[7:4];
      cmd <= LOG1_RESET[2:0];
    end else if (first_viol) begin
      req_id <= id_now; // [RULE4] [RULE5] [RULE6] [RULE7]
      region <= i_viol_region;
      cmd <= i_viol_cmd;
    end
  end

  // running count of violations, saturating
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      viol_count <= VIOL_RESET;
    end else if (i_viol_valid && viol_count != 16'hffff) begin
      viol_count <= viol_count + 16'h0001;
    end
  end

  assign o_error_logged = (code != CODE_NONE);
  assign o_multi = multi;

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_code_set;
    @(posedge i_sys_clk) disable iff (i_srst)
    first_viol |=> (code == CODE_PERM_VIOL);
  endproperty
  a_code_set: assert property (p_code_set) else $error("code not set on violation"); // [RULE1]

  property p_code_legal;
    @(posedge i_sys_clk) disable iff (i_srst)
    (code == CODE_NONE) || (code == CODE_PERM_VIOL);
  endproperty
  a_code_legal: assert property (p_code_legal) else $error("illegal code value"); // [RULE1]

  property p_code_clear;
    @(posedge i_sys_clk) disable iff (i_srst)
    (clr_code && !i_viol_valid) |=> (code == CODE_NONE);
  endproperty
  a_code_clear: assert property (p_code_clear) else $error("code not cleared"); // [RULE2]

  property p_multi_set;
    @(posedge i_sys_clk) disable iff (i_srst)
    again_viol |=> o_multi;
  endproperty
  a_multi_set: assert property (p_multi_set) else $error("multi not set"); // [RULE3]

  property p_multi_hold;
    @(posedge i_sys_clk) disable iff (i_srst)
    (multi && !clr_multi) |=> multi;
  endproperty
  a_multi_hold: assert property (p_multi_hold) else $error("multi dropped"); // [RULE3]

  property p_cpu_id;
    @(posedge i_sys_clk) disable iff (i_srst)
    (first_viol && i_viol_src == SRC_CPU) |=> (req_id == (i_cpu_pri ? 8'h02 : 8'h01)) || $changed(i_cpu_pri);
  endproperty
  a_cpu_id: assert property (p_cpu_id) else $error("bad processor identity"); // [RULE4]

  property p_dma_wr_id;
    @(posedge i_sys_clk) disable iff (i_srst)
    (first_viol && i_viol_src == SRC_DMA_WR && i_dma_pri) |=> (req_id == 8'h06);
  endproperty
  a_dma_wr_id: assert property (p_dma_wr_id) else $error("bad dma write identity"); // [RULE5]

  property p_fixed_id;
    @(posedge i_sys_clk) disable iff (i_srst)
    (first_viol && i_viol_src == SRC_CRYPTO) |=> (req_id == 8'h0e);
  endproperty
  a_fixed_id: assert property (p_fixed_id) else $error("bad crypto identity"); // [RULE6]

  property p_capture_hold;
    @(posedge i_sys_clk) disable iff (i_srst)
    again_viol |=> $stable(req_id) && $stable(region) && $stable(cmd);
  endproperty
  a_capture_hold: assert property (p_capture_hold) else $error("log overwritten"); // [RULE7]

  ////////////////////////////////////////////////////////////////////////
  // field positions of read data, flag lifetimes and the identity codes not checked above

  property p_log_read;
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_avs_read && o_avs_waitrequest && sel_log) |=> (o_avs_readdata[MULTI_BIT] == $past(multi))
      && (o_avs_readdata[CODE_LSB +: 4] == $past(code)) && (o_avs_readdata[REQ_ID_LSB +: 8] == $past(req_id))
      && (o_avs_readdata[REGION_LSB +: 4] == $past(region)) && (o_avs_readdata[CMD_LSB +: 3] == $past(cmd))
      && (o_avs_readdata[30:28] == 3'h0) && (o_avs_readdata[23:16] == 8'h00) && !o_avs_readdata[3];
  endproperty
  a_log_read: assert property (p_log_read) else $error("log read data wrong"); // [RULE1]

  property p_code_hold;
    @(posedge i_sys_clk) disable iff (i_srst)
    ((code == CODE_PERM_VIOL) && !clr_code) |=> (code == CODE_PERM_VIOL);
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("code lost without clear"); // [RULE2]

  property p_code_idle;
    @(posedge i_sys_clk) disable iff (i_srst)
    ((code == CODE_NONE) && !i_viol_valid) |=> (code == CODE_NONE);
  endproperty
  a_code_idle: assert property (p_code_idle) else $error("code set without violation"); // [RULE1]

  property p_multi_clear;
    @(posedge i_sys_clk) disable iff (i_srst)
    (clr_multi && !again_viol) |=> !multi;
  endproperty
  a_multi_clear: assert property (p_multi_clear) else $error("multi not cleared"); // [RULE3]

  property p_multi_idle;
    @(posedge i_sys_clk) disable iff (i_srst)
    (!multi && !again_viol) |=> !multi;
  endproperty
  a_multi_idle: assert property (p_multi_idle) else $error("multi set without repeat"); // [RULE3] [RULE7]

  property p_cpu_lo_id;
    @(posedge i_sys_clk) disable iff (i_srst)
    (first_viol && (i_viol_src == SRC_CPU) && !i_cpu_pri) |=> (req_id == 8'h01);
  endproperty
  a_cpu_lo_id: assert property (p_cpu_lo_id) else $error("bad processor low identity"); // [RULE4]

  property p_cpu_hi_id;
    @(posedge i_sys_clk) disable iff (i_srst)
    (first_viol && (i_viol_src == SRC_CPU) && i_cpu_pri) |=> (req_id == 8'h02);
  endproperty
  a_cpu_hi_id: assert property (p_cpu_hi_id) else $error("bad processor high identity"); // [RULE4]

  property p_dma_rd_hi_id;
    @(posedge i_sys_clk) disable iff (i_srst)
    (first_viol && (i_viol_src == SRC_DMA_RD) && i_dma_pri) |=> (req_id == 8'h04);
  endproperty
  a_dma_rd_hi_id: assert property (p_dma_rd_hi_id) else $error("bad dma read high identity"); // [RULE5]

  property p_dma_rd_lo_id;
    @(posedge i_sys_clk) disable iff (i_srst)
    (first_viol && (i_viol_src == SRC_DMA_RD) && !i_dma_pri) |=> (req_id == 8'h03);
  endproperty
  a_dma_rd_lo_id: assert property (p_dma_rd_lo_id) else $error("bad dma read low identity"); // [RULE5]

  property p_dma_wr_lo_id;
    @(posedge i_sys_clk) disable iff (i_srst)
    (first_viol && (i_viol_src == SRC_DMA_WR) && !i_dma_pri) |=> (req_id == 8'h05);
  endproperty
  a_dma_wr_lo_id: assert property (p_dma_wr_lo_id) else $error("bad dma write low identity"); // [RULE5]

  property p_usb_id;
    @(posedge i_sys_clk) disable iff (i_srst)
    (first_viol && (i_viol_src == SRC_USB)) |=> (req_id == 8'h07);
  endproperty
  a_usb_id: assert property (p_usb_id) else $error("bad usb identity"); // [RULE6]

  property p_net_rd_id;
    @(posedge i_sys_clk) disable iff (i_srst)
    (first_viol && (i_viol_src == SRC_NET_RD)) |=> (req_id == 8'h08);
  endproperty
  a_net_rd_id: assert property (p_net_rd_id) else $error("bad network read identity"); // [RULE6]

  property p_net_wr_id;
    @(posedge i_sys_clk) disable iff (i_srst)
    (first_viol && (i_viol_src == SRC_NET_WR)) |=> (req_id == 8'h09);
  endproperty
  a_net_wr_id: assert property (p_net_wr_id) else $error("bad network write identity"); // [RULE6]

  property p_can1_id;
    @(posedge i_sys_clk) disable iff (i_srst)
    (first_viol && (i_viol_src == SRC_CAN1)) |=> (req_id == 8'h0a);
  endproperty
  a_can1_id: assert property (p_can1_id) else $error("bad can1 identity"); // [RULE6]

  property p_can2_id;
    @(posedge i_sys_clk) disable iff (i_srst)
    (first_viol && (i_viol_src == SRC_CAN2)) |=> (req_id == 8'h0b);
  endproperty
  a_can2_id: assert property (p_can2_id) else $error("bad can2 identity"); // [RULE6]

  property p_sflash_id;
    @(posedge i_sys_clk) disable iff (i_srst)
    (first_viol && (i_viol_src == SRC_SFLASH)) |=> (req_id == 8'h0c);
  endproperty
  a_sflash_id: assert property (p_sflash_id) else $error("bad serial flash identity"); // [RULE6]

  property p_flash_id;
    @(posedge i_sys_clk) disable iff (i_srst)
    (first_viol && (i_viol_src == SRC_FLASH)) |=> (req_id == 8'h0d);
  endproperty
  a_flash_id: assert property (p_flash_id) else $error("bad flash controller identity"); // [RULE6]

  property p_reserved_id;
    @(posedge i_sys_clk) disable iff (i_srst)
    (first_viol && (i_viol_src > SRC_CRYPTO)) |=> (req_id == 8'h00);
  endproperty
  a_reserved_id: assert property (p_reserved_id) else $error("bad reserved identity"); // [RULE6]

  property p_capture_fields;
    @(posedge i_sys_clk) disable iff (i_srst)
    first_viol |=> (region == $past(i_viol_region)) && (cmd == $past(i_viol_cmd));
  endproperty
  a_capture_fields: assert property (p_capture_fields) else $error("region or command not captured"); // [RULE7]

endmodule // bus_target_error_log
`default_nettype wire

// file: tb/initiator_model.sv
`timescale 1ns/1ps
`default_nettype none
// bus initiator side: turns a request into one violation pulse
module initiator_model (
  input wire logic i_sys_clk, // clock
  input wire logic i_go, // request one pulse
  input wire logic [3:0] i_src, // source to report
  input wire logic [3:0] i_region, // region to report
  input wire logic [2:0] i_cmd, // command to report
  output logic o_viol_valid, // one-cycle pulse
  output logic [3:0] o_viol_src, // source
  output logic [3:0] o_viol_region, // region
  output logic [2:0] o_viol_cmd // command
);
  // fields flip outside a pulse so stale values never pass for valid ones
  always_ff @(posedge i_sys_clk) begin
    o_viol_valid <= i_go;
    o_viol_src <= i_go ? i_src : ~o_viol_src;
    o_viol_region <= i_go ? i_region : ~o_viol_region;
    o_viol_cmd <= i_go ? i_cmd : ~o_viol_cmd;
  end
endmodule // initiator_model
`default_nettype wire

// file: tb/bus_target_error_log_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module bus_target_error_log_tb_top;
  import bus_target_error_log_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic go = 1'b0;
  logic cpu_pri = 1'b0;
  logic dma_pri = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [3:0] gsrc = 4'h0;
  logic [3:0] greg = 4'h0;
  logic [2:0] gcmd = 3'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, q, exp_log;
  logic wait_req, vv, logged, multi;
  logic [3:0] vsrc, vreg;
  logic [2:0] vcmd;
  int bad_count = 0;
  int checks = 0;
  int seed = 38575;
  int nviol = 0;

  always #2.5 clk = ~clk;

  bus_target_error_log DUT (.i_sys_clk(clk), .i_srst(srst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .i_viol_valid(vv), .i_viol_src(vsrc), .i_viol_region(vreg),
    .i_viol_cmd(vcmd), .i_cpu_pri(cpu_pri), .i_dma_pri(dma_pri), .o_error_logged(logged), .o_multi(multi));
  initiator_model peer (.i_sys_clk(clk), .i_go(go), .i_src(gsrc), .i_region(greg), .i_cmd(gcmd),
    .o_viol_valid(vv), .o_viol_src(vsrc), .o_viol_region(vreg), .o_viol_cmd(vcmd));

  ////////////////////////////////////////////////////////////////
  // compare, count, report
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  // one avalon access, held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    if (n >= 50) chk("waitrequest", {31'h0, wait_req}, 32'h0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // expected requester identity
  function automatic logic [7:0] id_of(input int s, input int cp, input int dp);
    case (s)
      0: return cp ? 8'h02 : 8'h01;
      1: return dp ? 8'h04 : 8'h03;
      2: return dp ? 8'h06 : 8'h05;
      3, 4, 5, 6, 7, 8, 9, 10: return 8'(s + 4);
      default: return 8'h00;
    endcase
  endfunction

  task viol(input int s);
    logic [31:0] r;
    r = $random(seed);
    gsrc <= s[3:0];
    greg <= r[3:0];
    gcmd <= r[6:4];
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    nviol++;
    if (exp_log[27:24] == 4'h0) exp_log = {exp_log[31], 7'h03, 8'h0, id_of(s, cpu_pri, dma_pri), r[3:0], 1'b0, r[6:4]};
    else exp_log[31] = 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task look(input string nm, input logic [31:0] m);
    bus(1'b0, 4'h0, 32'h0);
    chk(nm, q & m, exp_log & m);
    chk("flags", {30'h0, multi, logged}, {30'h0, exp_log[31], |exp_log[27:24]});
  endtask

  task clr(input logic [31:0] d);
    logic [31:0] r;
    r = $random(seed);
    bus(1'b1, 4'h0, d | {8'h0, r[23:0]});
    if (d[31]) exp_log[31] = 1'b0;
    if (|d[27:24]) exp_log[27:24] = 4'h0;
  endtask

  task wrap_up;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // tests
  initial begin
    exp_log = 32'h0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    look("log reset", 32'hffffffff);
    bus(1'b0, 4'hc, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("test reset done");
    for (int p = 0; p < 4; p++) begin
      for (int s = 0; s < 12; s++) begin
        cpu_pri <= p[0];
        dma_pri <= p[1];
        @(posedge clk);
        viol(s);
        look("capture", 32'hffffffff);
        clr(32'h1 << (24 + s % 4));
        look("cleared", 32'hffffffff);
      end
    end
    $display("test capture done");
    viol(3);
    viol(9);
    look("multi", 32'hffffffff);
    clr(32'h80000000);
    look("multi clear", 32'hffffffff);
    bus(1'b1, 4'hc, 32'hffffffff);
    clr(32'h0f000000);
    look("code clear", 32'hffffffff);
    bus(1'b0, 4'h4, 32'h0);
    chk("count", q, 32'(nviol));
    $display("test multi done");
    wrap_up;
  end

  // watchdog
  initial begin
    #100000;
    bad_count++;
    wrap_up;
  end
endmodule // bus_target_error_log_tb_top
`default_nettype wire
